// >>> core/aps_top.sv
// module: auto parameter set sequencer with its avalon register slave
`timescale 1ns/100ps
`default_nettype none
module aps_top import aps_pkg::*; #(
  parameter int PARAM_W = 32,
  parameter int NSETS = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm register slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // frame timing pins
  input wire logic frame_trig,
  input wire logic frame_done,
  // parameters to the sensor path
  output logic [PARAM_W-1:0] applied_param,
  output logic [SET_IDX_W-1:0] cur_set,
  output logic seq_running
);
  // reset release synchroniser
  logic [1:0] rst_sync_ff;
  logic rst_n;
  // pin synchronisers and edge memory
  logic [1:0] trig_sync_ff;
  logic [1:0] done_sync_ff;
  logic trig_d_ff;
  logic done_d_ff;
  logic trig_rise;
  logic done_rise;
  // software registers
  logic sequencer_on_ff;
  logic mode_auto_n_ff; // 0 selects automatic advance
  logic [TOTAL_W-1:0] total_ff;
  logic [SET_IDX_W-1:0] index_ff;
  logic [EXEC_W-1:0] exec_ff;
  logic [PARAM_W-1:0] user_param_ff; // active set seen by software
  // bus handshake
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic bus_wr;
  logic bus_rd;
  // sequencer state
  aps_state_e state_ff;
  aps_state_e nxt_state;
  logic [SET_IDX_W-1:0] set_ff;
  logic [SET_IDX_W-1:0] nxt_set;
  logic [EXEC_W-1:0] uses_ff;
  logic first_ff; // next trigger is the first after enable
  logic busy_ff; // exposure or readout in progress
  logic load_pend_ff; // newly selected set still to be read out
  logic [PARAM_W-1:0] applied_ff;
  // decoded actions
  logic start_seq;
  logic stop_seq;
  logic step_seq;
  logic advance;
  logic do_store;
  logic do_load;

  // storage path between controller and sets
  aps_set_if #(.PARAM_W(PARAM_W), .IDX_W(SET_IDX_W), .EXEC_W(EXEC_W)) sif ();

  aps_set_store #(.NSETS(NSETS)) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif)
  );

  // clamp a written value into [lo, hi]
  function automatic logic [8:0] clamp9(input logic [31:0] v, input logic [8:0] lo, input logic [8:0] hi);
    if (v < {23'h0, lo}) begin
      clamp9 = lo;
    end else if (v > {23'h0, hi}) begin
      clamp9 = hi;
    end else begin
      clamp9 = v[8:0];
    end
  endfunction

  // next set in the cycle, wrapping at the cycle length
  function automatic logic [5:0] next_set(input logic [5:0] s, input logic [6:0] tot);
    if ({1'b0, s} + 7'h01 >= tot) begin
      next_set = 6'h00;
    end else begin
      next_set = s + 6'h01;
    end
  endfunction

  // reset: asserted at once, released through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // pin synchronisers, two flops each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_ff <= SYNC_RST;
      done_sync_ff <= SYNC_RST;
      trig_d_ff <= 1'b0;
      done_d_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[0], frame_trig};
      done_sync_ff <= {done_sync_ff[0], frame_done};
      trig_d_ff <= trig_sync_ff[1];
      done_d_ff <= done_sync_ff[1];
    end
  end
  // rising edges of the synchronised pins
  assign trig_rise = trig_sync_ff[1] & ~trig_d_ff;
  assign done_rise = done_sync_ff[1] & ~done_d_ff;

  // bus: request held one cycle with waitrequest high, then accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((read | write) & wait_ff);
    end
  end
  // write takes effect at the edge where waitrequest is low; read data is captured one edge earlier, while it is high
  assign bus_wr = write & ~wait_ff;
  assign bus_rd = read & wait_ff;

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (address)
      OFS_CTRL: begin
        nxt_rdata[CTRL_ON_BIT] = sequencer_on_ff;
        nxt_rdata[CTRL_MODE_BIT] = mode_auto_n_ff;
      end
      OFS_TOTAL: nxt_rdata[TOTAL_W-1:0] = total_ff;
      OFS_INDEX: nxt_rdata[SET_IDX_W-1:0] = index_ff;
      OFS_EXEC: nxt_rdata[EXEC_W-1:0] = exec_ff;
      OFS_ACTIVE: nxt_rdata[PARAM_W-1:0] = user_param_ff;
      OFS_STATUS: begin
        nxt_rdata[ST_SET_LSB +: SET_IDX_W] = set_ff;
        nxt_rdata[ST_USES_LSB +: EXEC_W] = uses_ff;
        nxt_rdata[ST_RUN_BIT] = (state_ff == ST_RUN);
        nxt_rdata[ST_BUSY_BIT] = busy_ff;
        nxt_rdata[ST_DRAIN_BIT] = (state_ff == ST_DRAIN);
      end
      OFS_APPLIED: nxt_rdata[PARAM_W-1:0] = applied_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured while waitrequest is high, stands at the accept edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // control register: enable and advance mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sequencer_on_ff <= 1'b0;
      mode_auto_n_ff <= 1'b0;
    end else if (bus_wr && address == OFS_CTRL) begin
      sequencer_on_ff <= writedata[CTRL_ON_BIT];
      // mode is only changed while off
      if (!sequencer_on_ff) begin
        mode_auto_n_ff <= writedata[CTRL_MODE_BIT];
      end
    end
  end

  // configuration registers, total and repeat count clamped into their ranges, index truncated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_ff <= TOTAL_RST;
      index_ff <= INDEX_RST;
      exec_ff <= EXEC_RST;
    end else if (bus_wr) begin
      // cycle length 1..64
      if (address == OFS_TOTAL && state_ff == ST_IDLE) begin
        total_ff <= TOTAL_W'(clamp9(writedata, {2'h0, TOTAL_MIN}, {2'h0, TOTAL_MAX}));
      end
      // selection index 0..63
      if (address == OFS_INDEX) begin
        index_ff <= writedata[SET_IDX_W-1:0];
      end
      // repeat count 1..256
      if (address == OFS_EXEC) begin
        exec_ff <= clamp9(writedata, EXEC_MIN, EXEC_MAX);
      end
    end
  end

  // store and load commands act only while the sequencer is idle
  assign do_store = bus_wr & (address == OFS_CMD) & writedata[CMD_STORE_BIT] & (state_ff == ST_IDLE);
  assign do_load = bus_wr & (address == OFS_CMD) & writedata[CMD_LOAD_BIT] & (state_ff == ST_IDLE);

  // software's active parameters; frozen while sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_param_ff <= PARAM_RST[PARAM_W-1:0];
    end else if (do_load) begin
      user_param_ff <= sif.rd_param;
    end else if (bus_wr && address == OFS_ACTIVE && state_ff == ST_IDLE && !sequencer_on_ff) begin
      user_param_ff <= writedata[PARAM_W-1:0];
    end
  end

  // storage write: active values plus repeat count into selected set
  assign sif.wr_en = do_store;
  assign sif.wr_idx = index_ff;
  assign sif.wr_param = user_param_ff;
  assign sif.wr_exec = exec_ff;

  // sequencer events
  assign start_seq = (state_ff == ST_IDLE) & sequencer_on_ff & ~mode_auto_n_ff;
  assign stop_seq = (state_ff != ST_IDLE) & ~sequencer_on_ff;
  assign step_seq = (state_ff == ST_RUN) & sequencer_on_ff & trig_rise;
  // compare uses so far with the current set's repeat count
  assign advance = step_seq & ~first_ff & (uses_ff >= sif.rd_exec);

  // read port looks at the current set, or the load target while idle
  always_comb begin
    nxt_set = set_ff;
    if (start_seq) begin
      nxt_set = 6'h00;
    end else if (advance) begin
      nxt_set = next_set(set_ff, total_ff);
    end
  end
  assign sif.rd_idx = (state_ff == ST_IDLE && !start_seq) ? index_ff : set_ff;

  // frame busy: set by trigger, cleared by end of transmission; set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (trig_rise && state_ff != ST_IDLE) begin
      busy_ff <= 1'b1;
    end else if (done_rise || state_ff == ST_IDLE) begin
      busy_ff <= 1'b0;
    end
  end

  // state machine: run, then drain the frame in flight on disable
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_seq) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_seq) begin
          // wait for the frame in flight before stopping
          nxt_state = (busy_ff && !done_rise) ? ST_DRAIN : ST_IDLE;
        end
      end
      ST_DRAIN: begin
        if (done_rise) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // set selection: moves only at trigger boundaries or on enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      set_ff <= 6'h00;
      load_pend_ff <= 1'b0;
    end else begin
      load_pend_ff <= start_seq | advance; // read port follows set_ff a cycle later
      if (start_seq || advance) begin
        set_ff <= nxt_set;
      end
    end
  end

  // consecutive use counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uses_ff <= 9'h000;
      first_ff <= 1'b0;
    end else if (start_seq) begin
      uses_ff <= 9'h000;
      first_ff <= 1'b1;
    end else if (step_seq) begin
      first_ff <= 1'b0;
      // advancing or first frame counts the new set's first use
      if (advance || first_ff) begin
        uses_ff <= 9'h001;
      end else begin
        uses_ff <= uses_ff + 9'h001;
      end
    end
  end

  // applied parameters: set contents while sequencing, software's otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_ff <= PARAM_RST[PARAM_W-1:0];
    end else if (state_ff == ST_IDLE && !start_seq) begin
      applied_ff <= user_param_ff;
    end else if (state_ff == ST_DRAIN) begin
      applied_ff <= applied_ff; // held until the frame is out
    end else if (load_pend_ff) begin
      // set 0 after enable, the next set after advance, once selected
      applied_ff <= sif.rd_param;
    end
  end

  // output flops: selection and running flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_set <= 6'h00;
      seq_running <= 1'b0;
    end else begin
      cur_set <= (state_ff == ST_IDLE) ? 6'h00 : set_ff;
      seq_running <= (state_ff != ST_IDLE);
    end
  end

  // bus outputs straight from flops
  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign applied_param = applied_ff;
endmodule
`default_nettype wire

// >>> core/aps_pkg.sv
// package: constants and types of the auto parameter set sequencer
package aps_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TOTAL = 5'h04;
  localparam logic [4:0] OFS_INDEX = 5'h08;
  localparam logic [4:0] OFS_EXEC = 5'h0C;
  localparam logic [4:0] OFS_CMD = 5'h10;
  localparam logic [4:0] OFS_ACTIVE = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam logic [4:0] OFS_APPLIED = 5'h1C;
  // field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int ST_SET_LSB = 0;
  localparam int ST_USES_LSB = 8;
  localparam int ST_RUN_BIT = 20;
  localparam int ST_BUSY_BIT = 21;
  localparam int ST_DRAIN_BIT = 22;
  // ranges
  localparam int SET_IDX_W = 6;
  localparam int TOTAL_W = 7;
  localparam int EXEC_W = 9;
  localparam logic [6:0] TOTAL_MIN = 7'h01;
  localparam logic [6:0] TOTAL_MAX = 7'h40;
  localparam logic [8:0] EXEC_MIN = 9'h001;
  localparam logic [8:0] EXEC_MAX = 9'h100;
  // values after reset
  localparam logic [6:0] TOTAL_RST = 7'h01;
  localparam logic [5:0] INDEX_RST = 6'h00;
  localparam logic [8:0] EXEC_RST = 9'h001;
  localparam logic [31:0] PARAM_RST = 32'h0000_0000;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DRAIN = 3'b100
  } aps_state_e;
endpackage

// >>> core/aps_set_if.sv
// interface: write and read paths into the parameter set storage
`timescale 1ns/100ps
`default_nettype none
interface aps_set_if #(parameter int PARAM_W = 32, parameter int IDX_W = 6, parameter int EXEC_W = 9);
  logic wr_en; // one-cycle store strobe
  logic [IDX_W-1:0] wr_idx; // set being stored
  logic [PARAM_W-1:0] wr_param; // parameters to store
  logic [EXEC_W-1:0] wr_exec; // repeat count to store
  logic [IDX_W-1:0] rd_idx; // set being looked at
  logic [PARAM_W-1:0] rd_param; // its parameters
  logic [EXEC_W-1:0] rd_exec; // its repeat count
  modport ctrl (output wr_en, wr_idx, wr_param, wr_exec, rd_idx, input rd_param, rd_exec);
  modport store (input wr_en, wr_idx, wr_param, wr_exec, rd_idx, output rd_param, rd_exec);
endinterface
`default_nettype wire

// >>> core/aps_set_store.sv
// module: flip-flop storage of all parameter sets and repeat counts
`timescale 1ns/100ps
`default_nettype none
module aps_set_store import aps_pkg::*; #(
  parameter int NSETS = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // storage port
  aps_set_if.store sif
);
  // one word of parameters and one repeat count per set
  logic [$bits(sif.wr_param)-1:0] param_ff [NSETS];
  logic [EXEC_W-1:0] exec_ff [NSETS];

  // volatile: every reset returns all sets to defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NSETS; i++) begin
        param_ff[i] <= PARAM_RST[$bits(sif.wr_param)-1:0];
        exec_ff[i] <= EXEC_RST;
      end
    end else if (sif.wr_en) begin
      // store overwrites whatever the set held
      param_ff[sif.wr_idx] <= sif.wr_param;
      exec_ff[sif.wr_idx] <= sif.wr_exec;
    end
  end

  // read mux by index
  assign sif.rd_param = param_ff[sif.rd_idx];
  assign sif.rd_exec = exec_ff[sif.rd_idx];
endmodule
`default_nettype wire

// >>> tb/aps_top_properties.sv
// checker: port properties of the sequencer top
`timescale 1ns/100ps
`default_nettype none
module aps_top_chk import aps_pkg::*; #(
  parameter int PARAM_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // frame pins and outputs
  input wire logic frame_trig,
  input wire logic frame_done,
  input wire logic [PARAM_W-1:0] applied_param,
  input wire logic [SET_IDX_W-1:0] cur_set,
  input wire logic seq_running
);
  logic trig_ff; // trigger pin last cycle
  logic done_ff; // done pin last cycle
  logic open_ff; // frame between trigger and done
  logic [3:0] age_ff; // cycles since trigger rise
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pin edges, open frame, trigger age
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_ff <= 1'b0;
      done_ff <= 1'b0;
      open_ff <= 1'b0;
      age_ff <= 4'hF;
    end else begin
      trig_ff <= frame_trig;
      done_ff <= frame_done;
      if (frame_trig && !trig_ff) begin
        open_ff <= 1'b1;
        age_ff <= 4'h0;
      end else begin
        if (frame_done && !done_ff) begin
          open_ff <= 1'b0;
        end
        if (age_ff != 4'hF) begin
          age_ff <= age_ff + 4'h1;
        end
      end
    end
  end
  a_wait_answer:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer in one cycle");
  a_wait_pulse:
    assert property (!waitrequest |=> waitrequest) else $error("accept longer than one cycle");
  a_unmapped_zero:
    assert property (read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0) else $error("odd read");
  a_set_on_trig:
    assert property (seq_running && $past(seq_running) && $changed(cur_set) |-> age_ff <= 4'h8)
      else $error("set changed without trigger");
  a_param_on_trig:
    assert property (seq_running && $past(seq_running, 3) && $changed(applied_param) |-> age_ff <= 4'h8)
      else $error("param changed without trigger");
  a_set_step:
    assert property (seq_running && $past(seq_running) && $changed(cur_set)
      |-> cur_set == $past(cur_set) + 6'h01 || cur_set == 6'h00) else $error("set skipped");
  a_start_set0:
    assert property ($rose(seq_running) |-> cur_set == 6'h00) else $error("start not at set 0");
  a_drain_done:
    assert property ($fell(seq_running) |-> !open_ff) else $error("stopped inside a frame");
  a_reset_quiet:
    assert property ($rose(reset_n) |-> waitrequest && !seq_running && applied_param == PARAM_RST)
      else $error("outputs not at reset values");
endmodule
bind aps_top aps_top_chk #(.PARAM_W(PARAM_W)) chk_i (.clk, .reset_n, .address, .read, .write, .readdata,
  .waitrequest, .frame_trig, .frame_done, .applied_param, .cur_set, .seq_running);
`default_nettype wire

// >>> tb/aps_frame_src.sv
// partner: frame trigger and frame done source
`timescale 1ns/100ps
`default_nettype none
module aps_frame_src (
  // clock and request
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] hold,
  // frame pins
  output logic frame_trig,
  output logic frame_done,
  output logic busy
);
  // one frame per go: trigger, exposure of hold cycles, done
  initial begin
    frame_trig = 1'b0;
    frame_done = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        frame_trig <= 1'b1;
        repeat (4) @(posedge clk);
        frame_trig <= 1'b0;
        repeat (hold) @(posedge clk);
        frame_done <= 1'b1;
        repeat (4) @(posedge clk);
        frame_done <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/aps_top_tb.sv
// testbench: register scenarios for the sequencer
`timescale 1ns/100ps
`default_nettype none
module aps_top_tb import aps_pkg::*; ;
  logic clk = 1'b0; // bench clock
  logic reset_n = 1'b0; // reset, low at start
  logic [4:0] address = 5'h00; // bus request
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata; // bus answer
  logic waitrequest;
  logic go = 1'b0; // frame request to partner
  logic [7:0] hold = 8'h08; // partner exposure
  logic frame_trig; // frame pins
  logic frame_done;
  logic busy;
  logic [31:0] applied_param; // outputs
  logic [5:0] cur_set;
  logic seq_running;
  logic [31:0] q; // last read
  logic [31:0] par[7]; // set parameters
  logic [8:0] ex[7] = '{9'h001, 9'h003, 9'h001, 9'h001, 9'h001, 9'h002, 9'h001}; // repeat counts
  logic [4:0] ra[6] = '{OFS_TOTAL, OFS_TOTAL, OFS_INDEX, OFS_EXEC, OFS_EXEC, OFS_EXEC}; // limit table
  logic [31:0] rv[6] = '{32'h7F, 32'h0, 32'h3F, 32'h0, 32'h1FF, 32'h100};
  logic [31:0] re[6] = '{32'h40, 32'h1, 32'h3F, 32'h1, 32'h100, 32'h100};
  int err_total = 0;
  int n_checks = 0;
  int s;
  int u;
  aps_top #(.PARAM_W(32), .NSETS(64)) uut (.clk, .reset_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .frame_trig, .frame_done, .applied_param, .cur_set, .seq_running);
  aps_frame_src src (.clk, .go, .hold, .frame_trig, .frame_done, .busy);
  // 100 MHz clock
  always #5 clk = ~clk;
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (waitrequest !== 1'b0) err_total++;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  // wait for a free partner
  task automatic idle_src;
    for (int n = 0; n < 300 && busy; n++) @(posedge clk);
  endtask
  // one frame from the partner
  task automatic launch(input logic [7:0] h);
    idle_src();
    hold <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // counts and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 7; i++) par[i] = (i == 6) ? PARAM_RST : {16'hC0DE, 16'(i + 1)};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, OFS_TOTAL, 32'h0);
    chk("total", q, {25'h0, TOTAL_RST});
    bus(1'b0, 5'h02, 32'h0);
    chk("unmapped", q, 32'h0);
    // limits of total, index, repeat count
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ra[i], rv[i]);
      bus(1'b0, ra[i], 32'h0);
      chk("limit", q, re[i]);
    end
    $display("test limits done");
    // other advance mode: enabling must not start the sequencer
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl mode", q, 32'h3);
    repeat (4) @(posedge clk);
    chk("other mode idle", {31'h0, seq_running}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0);
    // configure while off, set 6 left unstored
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_TOTAL, 32'h7);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_INDEX, 32'(i));
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, OFS_ACTIVE, k ? par[i] : ~par[i]);
        bus(1'b1, OFS_EXEC, k ? {23'h0, ex[i]} : 32'h5);
        bus(1'b1, OFS_CMD, 32'h1);
      end
    end
    bus(1'b1, OFS_INDEX, 32'h1);
    bus(1'b1, OFS_CMD, 32'h2);
    bus(1'b0, OFS_ACTIVE, 32'h0);
    chk("load", q, par[1]);
    bus(1'b1, OFS_ACTIVE, 32'h5A5A_0BEE);
    $display("test config done");
    // enable, then eleven frames, prompt and slow
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    chk("start param", applied_param, par[0]);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("start uses", {23'h0, q[16:8]}, 32'h0);
    s = 0;
    u = 0;
    for (int f = 0; f < 11; f++) begin
      if (u >= ex[s]) begin
        s = (s + 1) % 7;
        u = 1;
      end else begin
        u++;
      end
      launch(f[0] ? 8'h02 : 8'h1E);
      repeat (12) @(posedge clk);
      chk("set", {26'h0, cur_set}, 32'(s));
      chk("param", applied_param, par[s]);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("uses", {23'h0, q[16:8]}, 32'(u));
    end
    // disable inside a long frame
    launch(8'h3C);
    repeat (8) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0);
    chk("draining", {31'h0, seq_running}, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("drain flags", {30'h0, q[ST_DRAIN_BIT], q[ST_BUSY_BIT]}, 32'h3);
    idle_src();
    repeat (8) @(posedge clk);
    chk("stopped", {31'h0, seq_running}, 32'h0);
    chk("restored", applied_param, 32'h5A5A_0BEE);
    chk("idle set", {26'h0, cur_set}, 32'h0);
    $display("test cycling done");
    // second reset empties the sets
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b1, OFS_INDEX, 32'h1);
    bus(1'b1, OFS_CMD, 32'h2);
    bus(1'b0, OFS_ACTIVE, 32'h0);
    chk("after reset", q, PARAM_RST);
    $display("test reset done");
    test_done();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
